// ==== shared/io_pin_control_regs.vh ====
// Register offsets, field positions and codes of the input/output pin control block.
`ifndef IO_PIN_CONTROL_REGS_VH
`define IO_PIN_CONTROL_REGS_VH

// Register indices; the byte address is four times the index.
`define IO_CTRL_IDX 6'h03
`define AUX_CTRL_IDX 6'h10
`define PIN_STAT_IDX 6'h11
`define ADDR_W 8

// Pin control register layout.
`define IO_CTRL_RST 16'h0000
`define IO_CTRL_WMASK 16'h07FF
`define SYNC_CLR_BIT 10
`define ROUTE_HI 9
`define ROUTE_LO 8
`define LEVEL_HI 7
`define LEVEL_LO 4
`define DIR_HI 3
`define DIR_LO 0

// Interrupt routing codes.
`define ROUTE_INT_PIN 2'b00
`define ROUTE_CLK_PIN 2'b01
`define ROUTE_AUX2 2'b10
`define ROUTE_DOUT 2'b11

// Auxiliary control register layout.
`define AUX_CTRL_RST 16'h0000
`define AUX_CTRL_WMASK 16'h000F
`define CLKSEL_HI 1
`define CLKSEL_LO 0
`define FIFO_EN_BIT 2
`define STBY_EN_BIT 3
`define CLKSEL_INT_OUT 2'b01

// Pin status register layout.
`define STAT_AUX_HI 3
`define STAT_AUX_LO 0
`define STAT_IRQ_BIT 4
`define STAT_SYNC_BIT 5

// Auxiliary pin positions inside the four-bit pin vectors.
`define AUX2_POS 1
`define AUX4_POS 3
`define AUX_FN_RST 4'hF

// Bus answers.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define DATA_ZERO 32'h0000_0000

`endif

// ==== verif/io_host_model.sv ====
// Host side model: drives the sync pin and the undriven auxiliary lines.
`timescale 1ns/10ps
module io_host_model
(
	// Clock
	input wire clk_in,
	// Pins
	input wire [3:0] aux_out_in,
	input wire [3:0] aux_oe_in,
	output wire [3:0] aux_in_out,
	output logic sync_n_out
);
	// A line the device does not drive carries the host pattern, never a stale level.
	assign aux_in_out = (aux_oe_in & aux_out_in) | (~aux_oe_in & 4'hA);
	initial sync_n_out = 1'b1;
	// Held low three clocks so the device is sure to see it.
	task sync_pulse();
	begin
		@(posedge clk_in);
		sync_n_out <= 1'b0;
		repeat (3) @(posedge clk_in);
		sync_n_out <= 1'b1;
	end
	endtask
endmodule // io_host_model

// ==== verif/io_pin_control_sva.sv ====
// Port assertions for the pin control block.
`timescale 1ns/10ps
module io_pin_control_sva
(
	// Clock, reset and bus
	input wire CLK_SYS_IN,
	input wire RST_IN,
	input wire S_AXI_ARVALID_IN,
	input wire S_AXI_ARREADY_OUT,
	input wire [1:0] S_AXI_BRESP_OUT,
	input wire S_AXI_BVALID_OUT,
	input wire S_AXI_BREADY_IN,
	input wire [31:0] S_AXI_RDATA_OUT,
	input wire S_AXI_RVALID_OUT,
	// Events and pins
	input wire DATA_READY_IN,
	input wire FIFO_INT_IN,
	input wire FIFO_CLEAR_OUT,
	input wire INT_PIN_OUT,
	input wire DOUT_RDY_SEL_OUT,
	input wire DOUT_RDY_OUT,
	input wire [3:0] AUX_PIN_OE_OUT,
	input wire [3:0] AUX_INPUT_FN_OUT
);
	default clocking @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (RST_IN);
	clr_one_cycle_a: assert property (FIFO_CLEAR_OUT |=> !FIFO_CLEAR_OUT)
		else $error("clear pulse too long");
	int_one_pin_a: assert property (INT_PIN_OUT |-> !DOUT_RDY_SEL_OUT)
		else $error("interrupt on two pins");
	int_cause_a: assert property (INT_PIN_OUT |-> $past(DATA_READY_IN | FIFO_INT_IN))
		else $error("interrupt without event");
	dout_ready_a: assert property (DOUT_RDY_SEL_OUT && $past(DOUT_RDY_SEL_OUT)
		|-> DOUT_RDY_OUT == $past(DATA_READY_IN)) else $error("data out not data ready");
	input_fn_a: assert property (AUX_INPUT_FN_OUT == ~AUX_PIN_OE_OUT)
		else $error("input function wrong");
	reset_idle_a: assert property ($fell(RST_IN) |-> AUX_PIN_OE_OUT == 4'h0 && !INT_PIN_OUT)
		else $error("pins not idle after reset");
	resv_zero_a: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:11] == 21'h00_0000)
		else $error("reserved bits set");
	b_holds_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN
		|=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("write answer dropped");
	r_answer_a: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
		else $error("read answer late");
	cover property (FIFO_CLEAR_OUT);
	cover property (DOUT_RDY_SEL_OUT && DOUT_RDY_OUT);
	cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == 2'b10);
	cover property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN);
endmodule // io_pin_control_sva
bind io_pin_control io_pin_control_sva u_sva (.*);

// ==== verif/tb_io_pin_control.sv ====
// Self-checking bench for the pin control block.
`timescale 1ns/10ps
`include "io_pin_control_regs.vh"
`define CHK(a, b) \
	begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_io_pin_control;
	logic CLK_SYS_IN = 1'b0;
	logic RST_IN = 1'b1;
	logic [7:0] S_AXI_AWADDR_IN = 8'h00, S_AXI_ARADDR_IN = 8'h00;
	logic [2:0] S_AXI_AWPROT_IN = 3'h0, S_AXI_ARPROT_IN = 3'h0;
	logic [31:0] S_AXI_WDATA_IN = 32'h0000_0000;
	logic [3:0] S_AXI_WSTRB_IN = 4'hF;
	logic S_AXI_AWVALID_IN = 1'b0, S_AXI_WVALID_IN = 1'b0, S_AXI_BREADY_IN = 1'b0;
	logic S_AXI_ARVALID_IN = 1'b0, S_AXI_RREADY_IN = 1'b0;
	logic DATA_READY_IN = 1'b0, FIFO_INT_IN = 1'b0, STANDBY_STATE_IN = 1'b0, INT_CLK_IN = 1'b0;
	wire S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT;
	wire S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT;
	wire [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
	wire [31:0] S_AXI_RDATA_OUT;
	wire SYNC_N_IN, FIFO_CLEAR_OUT, INT_PIN_OUT, CLK_PIN_OUT, CLK_PIN_OE_OUT;
	wire DOUT_RDY_SEL_OUT, DOUT_RDY_OUT;
	wire [3:0] AUX_PIN_IN, AUX_PIN_OUT, AUX_PIN_OE_OUT, AUX_INPUT_FN_OUT;
	localparam logic [7:0] A_IO = {`IO_CTRL_IDX, 2'b00};
	localparam logic [7:0] A_AUX = {`AUX_CTRL_IDX, 2'b00};
	localparam logic [7:0] A_STAT = {`PIN_STAT_IDX, 2'b00};
	int n_errors = 0, checked = 0, cycles = 0;
	logic [7:0] clears = 8'h00;
	io_pin_control DUT (.*);
	io_host_model u_host (.clk_in(CLK_SYS_IN), .aux_out_in(AUX_PIN_OUT),
		.aux_oe_in(AUX_PIN_OE_OUT), .aux_in_out(AUX_PIN_IN), .sync_n_out(SYNC_N_IN));
	always #2 CLK_SYS_IN = ~CLK_SYS_IN;
	always @(posedge CLK_SYS_IN)
	begin
		cycles++;
		clears += FIFO_CLEAR_OUT;
		if (cycles == 4000)
		begin
			n_errors++;
			give_verdict();
		end
	end
	task give_verdict();
	begin
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
	begin
		@(posedge CLK_SYS_IN);
		S_AXI_AWADDR_IN <= a;
		S_AXI_WDATA_IN <= d;
		S_AXI_AWVALID_IN <= 1'b1;
		S_AXI_WVALID_IN <= 1'b1;
		do
		begin
			@(posedge CLK_SYS_IN);
			if (S_AXI_AWREADY_OUT)
				S_AXI_AWVALID_IN <= 1'b0;
			if (S_AXI_WREADY_OUT)
				S_AXI_WVALID_IN <= 1'b0;
		end while (S_AXI_AWVALID_IN | S_AXI_WVALID_IN);
		// Wait one cycle, so the ready rises a cycle after the answer; it is taken on the next clock.
		@(posedge CLK_SYS_IN);
		S_AXI_BREADY_IN <= 1'b1;
		do @(posedge CLK_SYS_IN); while (!S_AXI_BVALID_OUT);
		S_AXI_BREADY_IN <= 1'b0;
		`CHK(S_AXI_BRESP_OUT, e)
		repeat (2) @(posedge CLK_SYS_IN);
	end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
	begin
		@(posedge CLK_SYS_IN);
		S_AXI_ARADDR_IN <= a;
		S_AXI_ARVALID_IN <= 1'b1;
		do @(posedge CLK_SYS_IN); while (!S_AXI_ARREADY_OUT);
		S_AXI_ARVALID_IN <= 1'b0;
		S_AXI_RREADY_IN <= 1'b1;
		do @(posedge CLK_SYS_IN); while (!S_AXI_RVALID_OUT);
		S_AXI_RREADY_IN <= 1'b0;
		`CHK(S_AXI_RDATA_OUT, d)
		`CHK(S_AXI_RRESP_OUT, e)
	end
	endtask
	task t_gpo();
	begin
		rd(A_IO, 32'h0000_0000, `RESP_OKAY);
		`CHK(AUX_INPUT_FN_OUT, 4'hF)
		wr(A_IO, 32'h0000_F8F5, `RESP_OKAY);
		rd(A_IO, 32'h0000_00F5, `RESP_OKAY);
		`CHK(AUX_PIN_OE_OUT, 4'h5)
		`CHK(AUX_PIN_OUT & 4'h5, 4'h5)
		wr(A_IO, 32'h0000_0005, `RESP_OKAY);
		`CHK(AUX_PIN_OUT & 4'h5, 4'h0)
	end
	endtask
	task t_route();
	begin
		DATA_READY_IN <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			wr(A_IO, {22'h00_0000, c[1:0], 8'h02}, `RESP_OKAY);
			`CHK(INT_PIN_OUT, c == 0)
			`CHK(CLK_PIN_OE_OUT & CLK_PIN_OUT, c == 1)
			`CHK(AUX_PIN_OUT[1], c == 2)
			`CHK(DOUT_RDY_SEL_OUT & DOUT_RDY_OUT, c == 3)
		end
		wr(A_AUX, 32'h0000_0004, `RESP_OKAY);
		`CHK(DOUT_RDY_SEL_OUT, 1'b0)
		wr(A_IO, 32'h0000_0000, `RESP_OKAY);
		`CHK(INT_PIN_OUT, 1'b0)
		FIFO_INT_IN <= 1'b1;
		repeat (2) @(posedge CLK_SYS_IN);
		`CHK(INT_PIN_OUT, 1'b1)
	end
	endtask
	task t_misc();
	begin
		STANDBY_STATE_IN <= 1'b1;
		INT_CLK_IN <= 1'b1;
		wr(A_IO, 32'h0000_0008, `RESP_OKAY);
		wr(A_AUX, 32'h0000_0009, `RESP_OKAY);
		`CHK(AUX_PIN_OUT[3] & AUX_PIN_OE_OUT[3], 1'b1)
		`CHK(CLK_PIN_OE_OUT & CLK_PIN_OUT, 1'b1)
		// Undriven lines show the host pattern; a status write has no effect.
		wr(A_STAT, 32'h0000_FFFF, `RESP_OKAY);
		rd(A_STAT, 32'h0000_003A, `RESP_OKAY);
		DATA_READY_IN <= 1'b0;
		wr(A_IO, 32'h0000_0108, `RESP_OKAY);
		`CHK(CLK_PIN_OE_OUT, 1'b1)
		`CHK(CLK_PIN_OUT, 1'b0)
		wr(8'h20, 32'h0000_FFFF, `RESP_SLVERR);
		rd(8'h20, 32'h0000_0000, `RESP_SLVERR);
	end
	endtask
	task t_sync();
	begin
		clears = 8'h00;
		u_host.sync_pulse();
		repeat (8) @(posedge CLK_SYS_IN);
		`CHK(clears, 8'h00)
		wr(A_IO, 32'h0000_0400, `RESP_OKAY);
		clears = 8'h00;
		u_host.sync_pulse();
		repeat (8) @(posedge CLK_SYS_IN);
		`CHK(clears, 8'h01)
	end
	endtask
	initial
	begin
		repeat (5) @(posedge CLK_SYS_IN);
		RST_IN <= 1'b0;
		t_gpo();
		t_route();
		t_misc();
		t_sync();
		give_verdict();
	end
endmodule // tb_io_pin_control

// ==== verilog/io_pin_control.v ====
// Input/output pin control register with interrupt routing and auxiliary pin muxing.
// Operation
// - Sync pin pulse clears FIFO when enabled.
// - Bits 9:8 pick the interrupt output pin.
// - Data ready is event when FIFO off.
// - Code 00 routes interrupt to interrupt pin.
// - Code 01 routes interrupt to clock pin.
// - Code 10 routes interrupt to aux pin 2.
// - Code 11 puts data ready on data out when FIFO off.
// - Bits 7:4 set aux pin output levels.
// - Bits 3:0 make aux pins outputs.
// - Standby indicator owns aux pin 4 when enabled.
// - Routed interrupt owns aux pin 2 first.
// - Register resets to zero, inputs kept.
// - Clock code 01 drives internal clock out when route code is not 01.
`timescale 1ns/10ps
`include "io_pin_control_regs.vh"
module io_pin_control
(
	// Clock and reset
	input wire CLK_SYS_IN,
	input wire RST_IN,
	// AXI4-Lite write address
	input wire [`ADDR_W-1:0] S_AXI_AWADDR_IN,
	input wire [2:0] S_AXI_AWPROT_IN,
	input wire S_AXI_AWVALID_IN,
	output wire S_AXI_AWREADY_OUT,
	// AXI4-Lite write data
	input wire [31:0] S_AXI_WDATA_IN,
	input wire [3:0] S_AXI_WSTRB_IN,
	input wire S_AXI_WVALID_IN,
	output wire S_AXI_WREADY_OUT,
	// AXI4-Lite write response
	output reg [1:0] S_AXI_BRESP_OUT,
	output reg S_AXI_BVALID_OUT,
	input wire S_AXI_BREADY_IN,
	// AXI4-Lite read address
	input wire [`ADDR_W-1:0] S_AXI_ARADDR_IN,
	input wire [2:0] S_AXI_ARPROT_IN,
	input wire S_AXI_ARVALID_IN,
	output wire S_AXI_ARREADY_OUT,
	// AXI4-Lite read data
	output reg [31:0] S_AXI_RDATA_OUT,
	output reg [1:0] S_AXI_RRESP_OUT,
	output reg S_AXI_RVALID_OUT,
	input wire S_AXI_RREADY_IN,
	// Events from the converter core
	input wire DATA_READY_IN,
	input wire FIFO_INT_IN,
	input wire STANDBY_STATE_IN,
	input wire INT_CLK_IN,
	// Sync pin
	input wire SYNC_N_IN,
	output reg FIFO_CLEAR_OUT,
	// Dedicated interrupt pin
	output reg INT_PIN_OUT,
	// Clock pin
	output reg CLK_PIN_OUT,
	output reg CLK_PIN_OE_OUT,
	// Data out pin request to the serial port
	output reg DOUT_RDY_SEL_OUT,
	output reg DOUT_RDY_OUT,
	// Auxiliary pins 4 down to 1
	input wire [3:0] AUX_PIN_IN,
	output reg [3:0] AUX_PIN_OUT,
	output reg [3:0] AUX_PIN_OE_OUT,
	// Auxiliary pins that keep their specific input function
	output reg [3:0] AUX_INPUT_FN_OUT
);

	reg [15:0] io_ctrl_q;
	reg [15:0] aux_ctrl_q;
	reg [`ADDR_W-1:0] aw_addr_q;
	reg aw_held_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg w_held_q;
	reg [3:0] aux_meta_q;
	reg [3:0] aux_sync_q;
	reg [3:0] aux_out_d;
	reg [3:0] aux_oe_d;
	reg [31:0] rdata_d;
	reg [1:0] rresp_d;
	reg [15:0] wmask_d;
	reg [15:0] wdata16_d;
	reg clk_pin_d;
	reg clk_oe_d;

	wire sync_level;
	wire sync_fall;
	wire [1:0] route;
	wire [1:0] clk_sel;
	wire fifo_en;
	wire stby_en;
	wire irq_event;
	wire do_write;
	wire [5:0] w_idx;
	wire [5:0] r_idx;
	wire [15:0] stat_word;

	assign route = io_ctrl_q[`ROUTE_HI:`ROUTE_LO];
	assign clk_sel = aux_ctrl_q[`CLKSEL_HI:`CLKSEL_LO];
	assign fifo_en = aux_ctrl_q[`FIFO_EN_BIT];
	assign stby_en = aux_ctrl_q[`STBY_EN_BIT];

	// The event source follows the FIFO enable, never both at once.
	assign irq_event = fifo_en ? FIFO_INT_IN : DATA_READY_IN;

	// Sync pin crossing and edge detection.
	io_sync_fall u_sync
	(
		.clk_in(CLK_SYS_IN),
		.rst_in(RST_IN),
		.pin_n_in(SYNC_N_IN),
		.level_out(sync_level),
		.fall_out(sync_fall)
	);

	// Auxiliary pin inputs come from outside and pass two flip-flops.
	// They read as zero until two clocks after reset, whatever the pins show.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_aux_in
			always @(posedge CLK_SYS_IN)
			begin
				if (RST_IN)
				begin
					aux_meta_q[gi] <= 1'b0;
					aux_sync_q[gi] <= 1'b0;
				end
				else
				begin
					aux_meta_q[gi] <= AUX_PIN_IN[gi];
					aux_sync_q[gi] <= aux_meta_q[gi];
				end
			end
		end
	endgenerate

	// A new address or data beat is taken only while none is held.
	assign S_AXI_AWREADY_OUT = ~aw_held_q & ~S_AXI_BVALID_OUT;
	assign S_AXI_WREADY_OUT = ~w_held_q & ~S_AXI_BVALID_OUT;
	assign S_AXI_ARREADY_OUT = ~S_AXI_RVALID_OUT;
	assign do_write = aw_held_q & w_held_q;
	assign w_idx = aw_addr_q[`ADDR_W-1:2];
	assign r_idx = S_AXI_ARADDR_IN[`ADDR_W-1:2];

	always @(posedge CLK_SYS_IN)
	begin
		if (RST_IN)
		begin
			aw_addr_q <= {`ADDR_W{1'b0}};
			aw_held_q <= 1'b0;
			w_data_q <= `DATA_ZERO;
			w_strb_q <= 4'h0;
			w_held_q <= 1'b0;
		end
		else
		begin
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
			begin
				aw_addr_q <= S_AXI_AWADDR_IN;
				aw_held_q <= 1'b1;
			end
			else if (do_write)
			begin
				aw_held_q <= 1'b0;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
			begin
				w_data_q <= S_AXI_WDATA_IN;
				w_strb_q <= S_AXI_WSTRB_IN;
				w_held_q <= 1'b1;
			end
			else if (do_write)
			begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Byte strobes select which half of a 16-bit register is written.
	// Strobes of the upper two bytes are ignored, as no register is wider.
	always @*
	begin
		wmask_d = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
		wdata16_d = w_data_q[15:0];
	end

	always @(posedge CLK_SYS_IN)
	begin
		if (RST_IN)
		begin
			io_ctrl_q <= `IO_CTRL_RST;
			aux_ctrl_q <= `AUX_CTRL_RST;
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= `RESP_OKAY;
		end
		else
		begin
			if (do_write)
			begin
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT <= `RESP_OKAY;
				if (w_idx == `IO_CTRL_IDX)
				begin
					// Reserved bits stay zero whatever is written.
					io_ctrl_q <= (io_ctrl_q & ~(wmask_d & `IO_CTRL_WMASK))
						| (wdata16_d & wmask_d & `IO_CTRL_WMASK);
				end
				else if (w_idx == `AUX_CTRL_IDX)
				begin
					aux_ctrl_q <= (aux_ctrl_q & ~(wmask_d & `AUX_CTRL_WMASK))
						| (wdata16_d & wmask_d & `AUX_CTRL_WMASK);
				end
				else if (w_idx != `PIN_STAT_IDX)
				begin
					S_AXI_BRESP_OUT <= `RESP_SLVERR;
				end
			end
			else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
			begin
				S_AXI_BVALID_OUT <= 1'b0;
			end
		end
	end

	// The status word is for debug only; its aux pin levels lag the pads by two clocks, the sync level by three.
	assign stat_word = {10'h000, sync_level, irq_event, aux_sync_q};

	// Read decode; unmapped words answer with an error and zero data.
	always @*
	begin
		rdata_d = `DATA_ZERO;
		rresp_d = `RESP_OKAY;
		case (r_idx)
			`IO_CTRL_IDX:
				rdata_d = {16'h0000, io_ctrl_q & `IO_CTRL_WMASK};
			`AUX_CTRL_IDX:
				rdata_d = {16'h0000, aux_ctrl_q};
			`PIN_STAT_IDX:
				rdata_d = {16'h0000, stat_word};
			default:
				rresp_d = `RESP_SLVERR;
		endcase
	end

	always @(posedge CLK_SYS_IN)
	begin
		if (RST_IN)
		begin
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= `DATA_ZERO;
			S_AXI_RRESP_OUT <= `RESP_OKAY;
		end
		else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
		begin
			S_AXI_RVALID_OUT <= 1'b1;
			S_AXI_RDATA_OUT <= rdata_d;
			S_AXI_RRESP_OUT <= rresp_d;
		end
		else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
		begin
			S_AXI_RVALID_OUT <= 1'b0;
		end
	end

	// Clock pin: interrupt routing wins over the clock output selection.
	always @*
	begin
		clk_pin_d = 1'b0;
		clk_oe_d = 1'b0;
		if (route == `ROUTE_CLK_PIN)
		begin
			clk_pin_d = irq_event;
			clk_oe_d = 1'b1;
		end
		else if (clk_sel == `CLKSEL_INT_OUT)
		begin
			clk_pin_d = INT_CLK_IN;
			clk_oe_d = 1'b1;
		end
	end

	// Auxiliary pin muxing, in falling priority per pin.
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_aux_mux
			always @*
			begin
				aux_out_d[gi] = io_ctrl_q[`LEVEL_LO + gi] & io_ctrl_q[`DIR_LO + gi];
				aux_oe_d[gi] = io_ctrl_q[`DIR_LO + gi];
				if (gi == `AUX4_POS && stby_en)
				begin
					aux_out_d[gi] = STANDBY_STATE_IN;
					aux_oe_d[gi] = 1'b1;
				end
				else if (gi == `AUX2_POS && route == `ROUTE_AUX2)
				begin
					aux_out_d[gi] = irq_event;
					aux_oe_d[gi] = 1'b1;
				end
			end
		end
	endgenerate

	// Pin levels are registered so the pads see glitch-free outputs.
	always @(posedge CLK_SYS_IN)
	begin
		if (RST_IN)
		begin
			INT_PIN_OUT <= 1'b0;
			CLK_PIN_OUT <= 1'b0;
			CLK_PIN_OE_OUT <= 1'b0;
			DOUT_RDY_SEL_OUT <= 1'b0;
			DOUT_RDY_OUT <= 1'b0;
			AUX_PIN_OUT <= 4'h0;
			AUX_PIN_OE_OUT <= 4'h0;
			AUX_INPUT_FN_OUT <= `AUX_FN_RST;
			FIFO_CLEAR_OUT <= 1'b0;
		end
		else
		begin
			INT_PIN_OUT <= (route == `ROUTE_INT_PIN) & irq_event;
			CLK_PIN_OUT <= clk_pin_d;
			CLK_PIN_OE_OUT <= clk_oe_d;
			// The FIFO interrupt never goes out on data out.
			// Route code 11 with the FIFO enabled leaves data out to the serial port alone.
			DOUT_RDY_SEL_OUT <= (route == `ROUTE_DOUT) & ~fifo_en;
			DOUT_RDY_OUT <= (route == `ROUTE_DOUT) & ~fifo_en & DATA_READY_IN;
			AUX_PIN_OUT <= aux_out_d;
			AUX_PIN_OE_OUT <= aux_oe_d;
			AUX_INPUT_FN_OUT <= ~aux_oe_d;
			// A fall seen while clearing is disabled is dropped, not kept for later.
			FIFO_CLEAR_OUT <= sync_fall & io_ctrl_q[`SYNC_CLR_BIT];
		end
	end

endmodule // io_pin_control

// ==== verilog/io_sync_fall.v ====
// Two-stage synchroniser with falling edge detection for the active-low sync pin.
`timescale 1ns/10ps
module io_sync_fall
(
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Pin side
	input wire pin_n_in,
	// Synchronised results
	output reg level_out,
	output reg fall_out
);

	reg meta_q;
	reg sync_q;

	// The pin idles high, so reset to high to avoid a false edge after release.
	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			level_out <= 1'b1;
			fall_out <= 1'b0;
		end
		else
		begin
			meta_q <= pin_n_in;
			sync_q <= meta_q;
			level_out <= sync_q;
			fall_out <= level_out & ~sync_q;
		end
	end

endmodule // io_sync_fall
